//--- design/dwl_pkg.sv
/*
  Package for the write-leveling and training block: timing constants,
  command codes, register offsets and field positions.
  Assumes a 40 MHz core clock and a decoded command stream.
*/
package dwl_pkg;
   // ====================
   // Clock and timing
   // ====================
   localparam int CLK_PERIOD_PS          = 25000;
   localparam int VREF_SINGLE_STEP_NS    = 80;
   localparam int VREF_FULL_RANGE_NS     = 200;
   localparam int LEVELING_FEEDBACK_NS   = 20;
   localparam int LEVELING_FIRST_STROBE  = 40;
   // Longest times round down
   localparam int VREF_SHORT_CYC = VREF_SINGLE_STEP_NS * 1000 / CLK_PERIOD_PS;
   localparam int VREF_LONG_CYC  = VREF_FULL_RANGE_NS * 1000 / CLK_PERIOD_PS;

   // ====================
   // Training FIFO shape
   // ====================
   localparam int FIFO_DEPTH = 5;
   localparam int BURST_LEN  = 16;
   localparam int DQ_W       = 16;
   localparam int MASK_W     = 2;
   localparam int ENT_W      = BURST_LEN * (DQ_W + MASK_W);

   // ====================
   // Command codes on cmd_i
   // ====================
   typedef enum logic [2:0] {
      DWL_CMD_DES    = 3'h0,
      DWL_CMD_MPC1   = 3'h1,
      DWL_CMD_CAS2   = 3'h2,
      DWL_CMD_RD     = 3'h3,
      DWL_CMD_WR     = 3'h4,
      DWL_CMD_MRW    = 3'h5,
      DWL_CMD_PDE    = 3'h6,
      DWL_CMD_SRPDE  = 3'h7
   } dwl_cmd_e;

   // MPC-1 operand fields
   localparam int          MPC_EN_BIT  = 5;
   localparam logic [4:0]  MPC_WR_FIFO = 5'h07;
   localparam logic [4:0]  MPC_RD_FIFO = 5'h01;

   // Mode register numbers and fields
   localparam logic [5:0]  MR_LEVEL    = 6'h02;
   localparam logic [5:0]  MR_VREF     = 6'h0e;
   localparam int          WL_BIT      = 7;
   localparam int          RANGE_BIT   = 6;

   // ====================
   // AXI4-Lite register map
   // ====================
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_STATUS  = 8'h04;
   localparam logic [7:0]  REG_PTRS    = 8'h08;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

//--- design/dwl_lane_if.sv
/*
  Carrier between the top and its leveling-lane helper.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface dwl_lane_if;
   logic strobe_sync;
   logic ck_level;
   logic leveling;
   logic fb;
   logic fb_valid;
   modport lane (input strobe_sync, ck_level, leveling,
                 output fb, fb_valid);
   modport top  (output strobe_sync, ck_level, leveling,
                 input fb, fb_valid);
endinterface

//--- design/dwl_sync2.sv
/*
  Two-stage synchroniser for one level from outside the clock domain.
  Assumes the source is a pin.
*/
`timescale 1ns/1ps
module dwl_sync2 (
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_n_i,
   // Level
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_q;
   // ====================
   // Two flops; the first feeds only the second
   // ====================
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= 1'b0;
         q_o    <= 1'b0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule // dwl_sync2

//--- design/dwl_level_lane.sv
/*
  One strobe lane of write leveling: samples the clock level on each
  rising strobe edge and marks feedback valid from the second edge.
  Assumes synchronised inputs from the top.
*/
`timescale 1ns/1ps
module dwl_level_lane (
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_n_i,
   // Lane carrier
   dwl_lane_if.lane  lane
);
   logic       prev_q;
   logic [1:0] edges_q;
   logic       fb_q;
   wire        rise = lane.strobe_sync & ~prev_q;

   // ====================
   // Edge capture and valid qualification
   // ====================
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prev_q  <= 1'b0;
         edges_q <= 2'h0;
         fb_q    <= 1'b0;
      end else begin
         prev_q <= lane.strobe_sync;
         if (!lane.leveling) begin
            edges_q <= 2'h0;
         end else if (rise) begin
            fb_q <= lane.ck_level;       // Sample clock on rising strobe
            if (edges_q != 2'h2) begin
               edges_q <= edges_q + 2'h1;
            end
         end
      end
   end
   // Valid only from the second edge onward
   assign lane.fb       = fb_q;
   assign lane.fb_valid = (edges_q == 2'h2);
endmodule // dwl_level_lane

//--- design/dwl_top.sv
/*
  Write-leveling, reference-voltage settling and DQ training FIFO logic
  of one channel, with an AXI4-Lite status port; control register writes are accepted and ignored.
  Assumes commands arrive already decoded on mclk_i; strobe and clock
  sample pins come from outside and are synchronised here.
*/
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - Single-step reference change settles within 80 ns.
// - Multi-step reference change settles within 200 ns.
// - Reference range follows bit 6 of the reference register.
// - In leveling, clock is sampled on each rising strobe edge.
// - Low byte reports strobe 0, high byte reports strobe 1.
// - Each channel and strobe levels independently.
// - Leveling entered and left by bit 7 of mode register 2.
// - Data outputs undefined on leveling entry until feedback valid.
// - Feedback valid from second edge within 20 ns; code drives it on dq_o at the fourth mclk_i edge after the strobe pin rises.
// - MPC-1 with CA5 low is a no-op, else CA4:0 decoded.
// - Training write uses write latency from CAS-2.
// - Five training writes, one 16-beat burst each, stored.
// - Training read uses read latency from CAS-2.
// - Training reads do not alter entries.
// - Reads step 0 to 4 then wrap.
// - Write pointer reset on reset and power-down entries.
// - Normal read advances both pointers; training ops advance one.
// - Sixth write overwrites the first entry.
module dwl_top
   import dwl_pkg::*;
#(
   parameter int WL      = 8,
   parameter int RL      = 14
) (
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              reset_n_i,
   // Decoded command bus
   input  wire logic              cmd_valid_i,
   input  wire logic [2:0]        cmd_i,
   input  wire logic [5:0]        cmd_ca_i,
   input  wire logic [7:0]        cmd_op_i,
   input  wire logic [5:0]        cmd_mr_i,
   // Pin samples
   input  wire logic              ck_pin_i,
   input  wire logic [1:0]        dqs_pin_i,
   // Write data burst stream
   input  wire logic              wdata_valid_i,
   input  wire logic [DQ_W-1:0]   wdata_i,
   input  wire logic [MASK_W-1:0] wmask_i,
   // Data outputs
   output logic [DQ_W-1:0]        dq_o,
   output logic [DQ_W-1:0]        dq_oe_o,
   output logic [MASK_W-1:0]      dmi_o,
   // Reference and leveling status
   output logic [5:0]             vref_level_o,
   output logic                   vref_range_o,
   output logic                   vref_busy_o,
   output logic                   leveling_o,
   // AXI4-Lite
   input  wire logic [7:0]        s_awaddr,
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [31:0]       s_wdata,
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic [1:0]             s_bresp,
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   input  wire logic [7:0]        s_araddr,
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic [31:0]            s_rdata,
   output logic [1:0]             s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready
);
   localparam int PW = 3;
   localparam int CW = 8;
   localparam logic [PW-1:0] LAST = PW'(FIFO_DEPTH - 1);
   localparam int SHORT_C = VREF_SHORT_CYC;
   localparam int LONG_C  = VREF_LONG_CYC;

   // All checks run on the core clock outside reset
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   // ====================
   // Pin synchronisers and leveling lanes
   // ====================
   logic       ck_s;
   logic [1:0] dqs_s;
   logic       wl_q;
   logic [1:0] fb;
   logic [1:0] fbv;
   dwl_sync2 u_sck (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
                    .d_i(ck_pin_i), .q_o(ck_s));
   for (genvar g = 0; g < 2; g++) begin : g_lane
      dwl_lane_if lif ();
      dwl_sync2 u_sdqs (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
                        .d_i(dqs_pin_i[g]), .q_o(dqs_s[g]));
      assign lif.strobe_sync = dqs_s[g];
      assign lif.ck_level    = ck_s;
      assign lif.leveling    = wl_q;
      assign fb[g]           = lif.fb;
      assign fbv[g]          = lif.fb_valid;
      dwl_level_lane u_lane (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
                             .lane(lif)); // Strobes level apart
   end

   // ====================
   // Command decode
   // ====================
   wire is_mrw   = cmd_valid_i && cmd_i == DWL_CMD_MRW;
   wire mrw_wl   = is_mrw && cmd_mr_i == MR_LEVEL;
   wire mrw_vref = is_mrw && cmd_mr_i == MR_VREF;
   wire mpc_on   = cmd_valid_i && cmd_i == DWL_CMD_MPC1
                   && cmd_ca_i[MPC_EN_BIT];
   wire mpc_wr   = mpc_on && cmd_ca_i[4:0] == MPC_WR_FIFO;
   wire mpc_rd   = mpc_on && cmd_ca_i[4:0] == MPC_RD_FIFO;
   wire cas2     = cmd_valid_i && cmd_i == DWL_CMD_CAS2;
   wire nrm_rd   = cmd_valid_i && cmd_i == DWL_CMD_RD;
   wire pd_entry = cmd_valid_i &&
                   (cmd_i == DWL_CMD_PDE || cmd_i == DWL_CMD_SRPDE);

   // ====================
   // Leveling mode and reference voltage
   // ====================
   logic [5:0] vref_q;
   logic [CW-1:0] settle_q;
   wire [5:0] vnew = cmd_op_i[5:0];
   wire one_step = (vnew == vref_q + 6'h1) || (vnew + 6'h1 == vref_q);
   wire [CW-1:0] settle_d = one_step ? CW'(VREF_SHORT_CYC)
                                     : CW'(VREF_LONG_CYC);
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wl_q         <= 1'b0;
         vref_q       <= 6'h0;
         vref_range_o <= 1'b0;
         settle_q     <= '0;
      end else begin
         if (mrw_wl) wl_q <= cmd_op_i[WL_BIT];
         if (mrw_vref) begin
            vref_q       <= vnew;
            vref_range_o <= cmd_op_i[RANGE_BIT];
            settle_q     <= (vnew == vref_q) ? '0 : settle_d;
         end else if (settle_q != '0) begin
            settle_q <= settle_q - CW'(1);
         end
      end
   end
   // Busy shows for the settling time of the step size
   chk_vref_short: assert property (mrw_vref && one_step |->
      ##2 vref_busy_o ##[1:SHORT_C] !vref_busy_o) else $error("short settle");
   chk_vref_long: assert property (mrw_vref && !one_step
      && vnew != vref_q |-> ##2 vref_busy_o ##[1:LONG_C] !vref_busy_o)
      else $error("long settle");
   // Mode flag follows the written bit
   chk_level_mode: assert property (mrw_wl |-> ##2
      leveling_o == $past(cmd_op_i[WL_BIT], 2)) else $error("mode bit");

   // ====================
   // MPC-1 pending, awaiting its CAS-2
   // ====================
   logic pend_wr_q, pend_rd_q;
   wire  go_wr = pend_wr_q && cas2;
   wire  go_rd = pend_rd_q && cas2;
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pend_wr_q <= 1'b0;
         pend_rd_q <= 1'b0;
      end else begin
         pend_wr_q <= mpc_wr;
         pend_rd_q <= mpc_rd;
      end
   end

   // ====================
   // Latency pipes: CAS-2 edge starts the count
   // ====================
   logic [WL-1:0] wl_pipe_q;
   logic [RL:0] rl_pipe_q;
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wl_pipe_q <= '0;
         rl_pipe_q <= '0;
      end else begin
         wl_pipe_q <= {wl_pipe_q[WL-2:0], go_wr};
         rl_pipe_q <= {rl_pipe_q[RL-1:0], go_rd};
      end
   end
   // First beat is sampled WL edges after the CAS-2 edge
   wire wr_start = wl_pipe_q[WL-1];
   wire rd_start = rl_pipe_q[RL];

   // ====================
   // Training FIFO storage and pointers
   // ====================
   logic [DQ_W+MASK_W-1:0] mem_q [FIFO_DEPTH][BURST_LEN];
   logic [PW-1:0] wptr_q, rptr_q, wcap_q, rcap_q;
   logic [4:0]    wbeat_q, rbeat_q;
   wire [PW-1:0] wptr_n = (wptr_q == LAST) ? '0 : wptr_q + PW'(1);
   wire [PW-1:0] rptr_n = (rptr_q == LAST) ? '0 : rptr_q + PW'(1);
   wire wr_active = wbeat_q != '0 || wr_start;
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wptr_q  <= '0;
         rptr_q  <= '0;
         wcap_q  <= '0;
         rcap_q  <= '0;
         wbeat_q <= '0;
         rbeat_q <= '0;
      end else begin
         if (pd_entry) begin
            wptr_q <= '0;
         end else if (go_wr || nrm_rd) begin
            wptr_q <= wptr_n;                      // Wraps, 6th hits 0
         end
         if (go_rd || nrm_rd) rptr_q <= rptr_n;
         if (go_wr) wcap_q <= wptr_q;
         if (go_rd) rcap_q <= rptr_q;
         if (wr_start) wbeat_q <= 5'h1;
         else if (wbeat_q != '0 && wdata_valid_i)
            wbeat_q <= (wbeat_q == 5'(BURST_LEN - 1)) ? '0 : wbeat_q + 5'h1;
         if (rd_start) rbeat_q <= 5'h1;
         else if (rbeat_q != '0)
            rbeat_q <= (rbeat_q == 5'(BURST_LEN)) ? '0 : rbeat_q + 5'h1;
      end
   end
   // Burst store; only writes touch the array
   wire [3:0] wb_idx = wr_start ? 4'h0 : wbeat_q[3:0];
   always_ff @(posedge mclk_i) begin
      if (wr_active && wdata_valid_i)
         mem_q[wcap_q][wb_idx] <= {wmask_i, wdata_i};
   end
   // Pointers stay in the five entries; power-down clears the write one
   chk_ptr_range: assert property (wptr_q <= LAST &&
      rptr_q <= LAST) else $error("pointer range");
   chk_ptr_clear: assert property (pd_entry |=> wptr_q == '0)
      else $error("pointer clear");

   // ====================
   // Output drive: leveling feedback or FIFO readback
   // ====================
   wire       rd_on  = rbeat_q != '0;
   wire [3:0] rb_idx = rbeat_q[3:0] - 4'h1;
   wire [DQ_W+MASK_W-1:0] rword = mem_q[rcap_q][rb_idx];
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dq_o    <= '0;
         dq_oe_o <= '0;
         dmi_o   <= '0;
      end else if (wl_q) begin
         // Low byte strobe 0, high byte strobe 1 zero until valid
         dq_o    <= {{8{fb[1] & fbv[1]}}, {8{fb[0] & fbv[0]}}};
         dq_oe_o <= '1;
         dmi_o   <= '0;
      end else if (rd_on) begin
         dq_o    <= rword[DQ_W-1:0];
         dq_oe_o <= '1;
         dmi_o   <= rword[DQ_W+MASK_W-1:DQ_W];
      end else begin
         dq_o    <= '0;
         dq_oe_o <= '0;
         dmi_o   <= '0;
      end
   end
   // No feedback shows before the second strobe edge
   chk_fb_zero: assert property (wl_q && fbv == 2'h0 |=>
      dq_o == '0) else $error("early feedback");
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         vref_level_o <= 6'h0;
         vref_busy_o  <= 1'b0;
         leveling_o   <= 1'b0;
      end else begin
         vref_level_o <= vref_q;
         vref_busy_o  <= settle_q != '0;
         leveling_o   <= wl_q;
      end
   end

   // ====================
   // AXI4-Lite slave: status readback
   // ====================
   logic aw_q, w_q;
   logic [7:0] awa_q;
   wire aw_hs = s_awvalid && s_awready;
   wire w_hs  = s_wvalid && s_wready;
   wire wdo   = (aw_q || aw_hs) && (w_q || w_hs) && !s_bvalid;
   wire [7:0] wa = aw_hs ? s_awaddr : awa_q;
   wire [31:0] rmux =
      (s_araddr == REG_STATUS) ? {24'h0, fbv, fb, 1'b0, vref_range_o,
                                  settle_q != '0, wl_q} :
      (s_araddr == REG_PTRS)   ? {24'h0, 1'b0, wptr_q, 1'b0, rptr_q} :
      32'h0;
   wire rok = s_araddr == REG_STATUS || s_araddr == REG_PTRS
              || s_araddr == REG_CTRL;
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 8'h0;
         s_awready <= 1'b1;
         s_wready <= 1'b1;
         s_bvalid <= 1'b0;
         s_bresp <= RESP_OKAY;
         s_arready <= 1'b1;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0;
         s_rresp <= RESP_OKAY;
      end else begin
         if (aw_hs) begin
            aw_q <= 1'b1;
            awa_q <= s_awaddr;
            s_awready <= 1'b0;
         end
         if (w_hs) begin
            w_q <= 1'b1;
            s_wready <= 1'b0;
         end
         if (wdo) begin
            s_bvalid <= 1'b1;
            s_bresp  <= (wa == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
            aw_q <= 1'b0;
            w_q <= 1'b0;
         end
         if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
         end
         if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rdata <= rmux;
            s_rresp <= rok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
            s_arready <= 1'b1;
         end
      end
   end
endmodule // dwl_top

//--- verif/dwl_ctrl_model.sv
/*
  Controller model: commands, write beats, clock level, strobes.
  Assumes tasks are called just after a rising mclk_i edge.
*/
`timescale 1ns/1ps
module dwl_ctrl_model
   import dwl_pkg::*;
#(
   parameter int WL = 8
) (
   // Clock
   input  wire logic         mclk_i,
   // Command bus
   output logic              cmd_valid_o,
   output logic [2:0]        cmd_o,
   output logic [5:0]        ca_o,
   output logic [7:0]        op_o,
   output logic [5:0]        mr_o,
   // Pin levels
   output logic              ck_o,
   output logic [1:0]        dqs_o,
   // Write beats
   output logic              wvalid_o,
   output logic [DQ_W-1:0]   wdata_o,
   output logic [MASK_W-1:0] wmask_o
);
   // ====================
   // Idle levels
   // ====================
   // Strobes park low, bus idles with deselect
   initial begin
      cmd_valid_o = 1'b0;
      cmd_o       = DWL_CMD_DES;
      ca_o        = 6'h00;
      op_o        = 8'h00;
      mr_o        = 6'h00;
      ck_o        = 1'b0;
      dqs_o       = 2'h0;
      wvalid_o    = 1'b0;
      wdata_o     = 16'h0000;
      wmask_o     = 2'h0;
   end

   // ====================
   // Command tasks
   // ====================
   // One command per edge; callers chain them back to back
   task automatic cmd(input logic [2:0] c, input logic [5:0] ca,
                      input logic [7:0] op, input logic [5:0] mr);
      @(posedge mclk_i);
      cmd_valid_o <= 1'b1;
      cmd_o       <= c;
      ca_o        <= ca;
      op_o        <= op;
      mr_o        <= mr;
   endtask

   // Deselect, CA operand inverted
   task automatic idle();
      @(posedge mclk_i);
      cmd_valid_o <= 1'b0;
      cmd_o       <= DWL_CMD_DES;
      ca_o        <= ~ca_o;
   endtask

   // Mode register write then deselect
   task automatic mrw(input logic [5:0] mr, input logic [7:0] op);
      cmd(DWL_CMD_MRW, 6'h00, op, mr);
      idle();
   endtask

   // Training write: MPC-1, zero CAS-2, beats WL edges later
   task automatic wr_train(input logic [3:0] e, input logic en);
      int b;
      cmd(DWL_CMD_MPC1, {en, MPC_WR_FIFO}, 8'h00, 6'h00);
      cmd(DWL_CMD_CAS2, 6'h00, 8'h00, 6'h00);
      idle();
      repeat (WL - 1) @(posedge mclk_i);
      for (b = 0; b < BURST_LEN; b++) begin
         wvalid_o <= 1'b1;
         wdata_o  <= {4'ha, e, 4'h5, 4'(b)};
         wmask_o  <= 2'(b);
         @(posedge mclk_i);
      end
      wvalid_o <= 1'b0;
      wdata_o  <= ~wdata_o;
   endtask

   // Leveling entry, wait for first strobe
   task automatic level_on();
      mrw(MR_LEVEL, 8'h80);
      repeat (LEVELING_FIRST_STROBE) @(posedge mclk_i);
   endtask

   // Clock level set first, then strobe pulses on one lane
   task automatic pulse(input int lane, input int n, input logic ck);
      @(posedge mclk_i);
      ck_o <= ck;
      repeat (n) begin
         @(posedge mclk_i);
         dqs_o[lane] <= 1'b1;
         repeat (2) @(posedge mclk_i);
         dqs_o[lane] <= 1'b0;
         @(posedge mclk_i);
      end
   endtask
endmodule // dwl_ctrl_model

//--- verif/tb_top.sv
/*
  Bench for dwl_top. Assumes the controller model at the far side.
*/
`timescale 1ns/1ps
module tb_top;
   import dwl_pkg::*;
   localparam int WL = 8;
   localparam int RL = 14;
   // ====================
   // Signals
   // ====================
   // Clock, reset, commands, pins and outputs
   logic              mclk_i    = 1'b0;
   logic              reset_n_i = 1'b0;
   logic              cmd_valid_i, ck_pin_i, wdata_valid_i;
   logic [2:0]        cmd_i;
   logic [5:0]        cmd_ca_i, cmd_mr_i, vref_level_o;
   logic [7:0]        cmd_op_i;
   logic [1:0]        dqs_pin_i;
   logic [DQ_W-1:0]   wdata_i, dq_o, dq_oe_o;
   logic [MASK_W-1:0] wmask_i, dmi_o;
   logic              vref_range_o, vref_busy_o, leveling_o;
   // Register port
   logic [7:0]        s_awaddr  = 8'h00;
   logic [7:0]        s_araddr  = 8'h00;
   logic [31:0]       s_wdata   = 32'h0;
   logic [3:0]        s_wstrb   = 4'hf;
   logic              s_awvalid = 1'b0;
   logic              s_wvalid  = 1'b0;
   logic              s_bready  = 1'b0;
   logic              s_arvalid = 1'b0;
   logic              s_rready  = 1'b0;
   logic              s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0]        s_bresp, s_rresp;
   logic [31:0]       s_rdata;
   int                err_count = 0;
   int                tests_run = 0;

   // ====================
   // Design and controller model
   // ====================
   dwl_top #(.WL(WL), .RL(RL)) uut (.*);
   // Controller drives commands, pins and beats
   dwl_ctrl_model #(.WL(WL)) mdl (
      .mclk_i      (mclk_i),
      .cmd_valid_o (cmd_valid_i),
      .cmd_o       (cmd_i),
      .ca_o        (cmd_ca_i),
      .op_o        (cmd_op_i),
      .mr_o        (cmd_mr_i),
      .ck_o        (ck_pin_i),
      .dqs_o       (dqs_pin_i),
      .wvalid_o    (wdata_valid_i),
      .wdata_o     (wdata_i),
      .wmask_o     (wmask_i)
   );
   // Core clock, 25 ns period
   always #12.5 mclk_i = ~mclk_i;

   // ====================
   // Reporting and bus tasks
   // ====================
   // Count a check; true on failure
   function automatic bit bad(input bit ok);
      tests_run++;
      return !ok;
   endfunction
   // Report one mismatch
   task automatic err(input string m);
      err_count++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   // Verdict, end of run
   task automatic print_verdict();
      if (err_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // A bounded wait ran out
   task automatic hang(input string m);
      err(m);
      print_verdict();
   endtask
   // Register write, address and data offered together
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      int n;
      @(posedge mclk_i);
      s_awaddr  <= a;
      s_wdata   <= d;
      s_awvalid <= 1'b1;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk_i);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
         if (s_bvalid) break;
      end
      r = s_bresp;
      s_bready <= 1'b0;
      if (n == 40) hang("write timeout");
   endtask
   // Register read
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int n;
      @(posedge mclk_i);
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk_i);
         if (s_arready) s_arvalid <= 1'b0;
         if (s_rvalid) break;
      end
      d = s_rdata;
      r = s_rresp;
      s_rready <= 1'b0;
      if (n == 40) hang("read timeout");
   endtask

   // ====================
   // Scenarios
   // ====================
   // Reset state, unmapped and write-only registers
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      if (bad({s_awready, s_arready, dq_o} === 18'h30000)) err("reset");
      axi_rd(8'h40, d, r);
      if (bad(r === RESP_SLVERR)) err("unmapped read");
      axi_wr(8'h40, 32'h1, r);
      if (bad(r === RESP_SLVERR)) err("unmapped write");
      axi_wr(REG_CTRL, 32'h1, r);
      if (bad(r === RESP_OKAY)) err("ctrl write");
      axi_rd(REG_CTRL, d, r);
      if (bad({r, d} === {RESP_OKAY, 32'h0})) err("ctrl read");
   endtask
   // Busy cycles seen after one reference write
   task automatic mrw_busy(input logic [7:0] op, output int c);
      c = 0;
      mdl.mrw(MR_VREF, op);
      repeat (20) begin
         @(posedge mclk_i);
         if (vref_busy_o === 1'b1) c++;
      end
   endtask
   // Single step, multi-step and both ranges
   task automatic t_vref();
      int c;
      mrw_busy(8'h01, c);
      if (bad(c > 0 && c <= VREF_SHORT_CYC)) err("step busy");
      mrw_busy(8'h68, c);
      if (bad(c > 0 && c <= VREF_LONG_CYC)) err("range busy");
      if (bad({vref_range_o, vref_level_o} === 7'h68)) err("rng1");
      mrw_busy(8'h28, c);
      if (bad({vref_range_o, vref_level_o} === 7'h28)) err("rng0");
   endtask
   // Pulse one lane and compare both feedback bytes
   task automatic lv(input int l, input int n, input logic k,
                     input logic [15:0] x);
      mdl.pulse(l, n, k);
      repeat (4) @(posedge mclk_i);
      if (bad(dq_o === x)) err("leveling feedback");
   endtask
   // Leveling entry, per-lane feedback, status, exit
   task automatic t_level();
      logic [31:0] d;
      logic [1:0]  r;
      mdl.level_on();
      if (bad(leveling_o === 1'b1)) err("leveling entry");
      lv(0, 1, 1'b1, 16'h0000);
      lv(0, 1, 1'b1, 16'h00ff);
      lv(0, 1, 1'b0, 16'h0000);
      lv(1, 2, 1'b1, 16'hff00);
      axi_rd(REG_STATUS, d, r);
      if (bad(d[7:0] === 8'he1)) err("status feedback");
      mdl.mrw(MR_LEVEL, 8'h00);
      repeat (4) @(posedge mclk_i);
      if (bad(leveling_o === 1'b0)) err("leveling exit");
   endtask
   // Training read of one entry, all 16 beats compared
   task automatic rd_train(input logic [3:0] e);
      int n;
      int b;
      mdl.cmd(DWL_CMD_MPC1, {1'b1, MPC_RD_FIFO}, 8'h00, 6'h00);
      mdl.cmd(DWL_CMD_CAS2, 6'h00, 8'h00, 6'h00);
      mdl.idle();
      for (n = 0; n < 60 && dq_oe_o === 16'h0; n++) @(posedge mclk_i);
      if (n == 60) hang("no read burst");
      if (bad(n >= RL && n <= RL + 4)) err("read latency");
      for (b = 0; b < BURST_LEN; b++) begin
         if (bad({dq_o, dmi_o} === {4'ha, e, 4'h5, 4'(b), 2'(b)}))
            err("fifo data");
         @(posedge mclk_i);
      end
   endtask
   // Training reads, expected entry ids one per nibble
   task automatic rd_seq(input logic [31:0] s, input int k);
      int i;
      for (i = 0; i < k; i++) rd_train(s[4*i+:4]);
   endtask
   // FIFO fill, wrap, overwrite, no-op, pointer moves and resets
   task automatic t_fifo();
      int e;
      for (e = 0; e < FIFO_DEPTH; e++) mdl.wr_train(4'(e), 1'b1);
      rd_seq(32'h00043210, 6);
      mdl.wr_train(4'h5, 1'b1);
      rd_seq(32'h00054321, 5);
      mdl.wr_train(4'h9, 1'b0);
      rd_seq(32'h00000001, 1);
      mdl.cmd(DWL_CMD_RD, 6'h00, 8'h00, 6'h00);
      mdl.idle();
      repeat (40) @(posedge mclk_i);
      rd_seq(32'h00000003, 1);
      mdl.wr_train(4'h7, 1'b1);
      rd_seq(32'h00007154, 4);
      mdl.cmd(DWL_CMD_PDE, 6'h00, 8'h00, 6'h00);
      mdl.idle();
      mdl.wr_train(4'h8, 1'b1);
      rd_seq(32'h00000843, 3);
      mdl.cmd(DWL_CMD_SRPDE, 6'h00, 8'h00, 6'h00);
      mdl.idle();
      mdl.wr_train(4'h6, 1'b1);
      rd_seq(32'h00064371, 5);
   endtask

   // ====================
   // Main sequence
   // ====================
   // Reset for eight cycles, then each scenario in turn
   initial begin
      repeat (8) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      @(posedge mclk_i);
      t_regs();
      t_vref();
      t_level();
      t_fifo();
      print_verdict();
   end
endmodule // tb_top
